// *** logic/fcs_sequencer.v ***
`timescale 1ns/100ps
`include "fcs_consts.vh"

// Operation
// RULE1: Software checks flags clear before launching
// RULE2: Busy ignores parameter writes, no launch
// RULE3: Idle parameter writes accepted any order
// RULE4: Write one to done flag launches
// RULE5: Error flags block launching
// RULE6: Software clears errors, then launches
// RULE7: Bad code or address sets access error
// RULE8: Protected program/erase target sets violation
// RULE9: Failed checks skip execution, set done
// RULE10: Execution failures set runtime error bit
// RULE11: Results stored, then done flag set
// RULE12: Decode 0x01, 0x02, 0x03
// RULE13: Decode 0x06 and 0x09
// RULE14: Decode 0x40 and 0x44
// RULE15: One-time field read/program, 64 bytes
// RULE16: Decode 0x45 key compare
// RULE17: Command availability by mode and security
// RULE18: Block erase refused if any protection
// RULE19: Margin level only during margin commands
// RULE20: Unknown code or bad field aborts
// RULE21: Same-block read during command flags collision
// RULE22: Section check address and count layout
// RULE23: Parameter group big-endian, code first
// RULE24: Completion and collision interrupt requests
// RULE25: Reset leaves controller idle, flags clear (code resets the done flag to set, status 0x80)
module fcs_sequencer #(
  parameter ADDR_W     = 24,
  parameter FLASH_SIZE = `FCS_FLASH_SIZE,
  parameter EXEC_CYC   = `FCS_EXEC_CYC
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire        array_rd,
  input  wire        exec_fail,
  input  wire [31:0] exec_rdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         cmd_start,
  output reg  [7:0]  cmd_code,
  output reg  [1:0]  margin_level,
  output reg         irq_req
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'b001;
  localparam ST_CHECK = 3'b010;
  localparam ST_EXEC  = 3'b100;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [7:0]  param_ff [0:`FCS_PARAM_NUM-1];
  reg [2:0]  state_ff;
  reg        cmd_complete_flag_ff;
  reg        access_error_flag_ff;
  reg        pviol_ff;
  reg        rterr_ff;
  reg        rdcol_ff;
  reg        complete_irq_enable_ff;
  reg        rdcolie_ff;
  reg [31:0] protect_ff;
  reg [3:0]  mode_ff;
  reg [7:0]  cnt_ff;
  reg [1:0]  mrg_sel;
  integer    i;

  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire idle   = (state_ff == ST_IDLE);
  wire pidx_h = (paddr >= `FCS_OFS_PARAM0) &&
                (paddr < `FCS_OFS_PARAM0 + 4 * `FCS_PARAM_NUM);
  wire [3:0] pidx = paddr[5:2] - 4'h8;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function is_known;
    input [7:0] c;
    begin
      case (c)
        `FCS_CMD_RD1SECT: is_known = 1'b1; // RULE12
        `FCS_CMD_PGMCHK:  is_known = 1'b1; // RULE12
        `FCS_CMD_RDRES:   is_known = 1'b1; // RULE12
        `FCS_CMD_PGM4:    is_known = 1'b1; // RULE13
        `FCS_CMD_ERSSECT: is_known = 1'b1; // RULE13
        `FCS_CMD_RD1ALL:  is_known = 1'b1; // RULE14
        `FCS_CMD_ERSALL:  is_known = 1'b1; // RULE14
        `FCS_CMD_RDONCE:  is_known = 1'b1; // RULE15
        `FCS_CMD_PGMONCE: is_known = 1'b1; // RULE15
        `FCS_CMD_VFYKEY:  is_known = 1'b1; // RULE16
        default:          is_known = 1'b0;
      endcase
    end
  endfunction

  function allowed;
    input [7:0] c;
    input [3:0] m;
    begin
      if (!m[`FCS_MD_SPECIAL])
        allowed = 1'b1;
      else if (m[`FCS_MD_MASS_ERASE_ENABLE_FIELD_LO+1:`FCS_MD_MASS_ERASE_ENABLE_FIELD_LO] == `FCS_MASS_ERASE_ENABLE_FIELD_DIS)
        allowed = 1'b0;
      else if (m[`FCS_MD_SECURE])
        allowed = (c == `FCS_CMD_RD1ALL) || (c == `FCS_CMD_ERSALL);
      else
        allowed = 1'b1; // RULE17
    end
  endfunction

  // Big-endian address from bytes 1..3
  wire [23:0] cmd_addr = {param_ff[1], param_ff[2], param_ff[3]}; // RULE23
  wire [15:0] sect_cnt = {param_ff[4], param_ff[5]}; // RULE22
  wire [7:0]  code     = param_ff[0];
  wire        aligned  = (cmd_addr[1:0] == 2'b00);
  wire [4:0]  region   = cmd_addr[15:11];
  wire        in_flash = (cmd_addr < FLASH_SIZE);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  reg chk_acc;
  reg chk_prot;
  always @* begin
    chk_acc  = ~is_known(code) | ~allowed(code, mode_ff); // RULE20 RULE7
    chk_prot = 1'b0;
    mrg_sel  = `FCS_MRG_NORMAL;
    case (code)
      `FCS_CMD_RD1SECT: begin
        chk_acc = chk_acc | ~aligned | ~in_flash | (sect_cnt == 16'h0000)
                  | (param_ff[6] > 8'h02); // RULE22
        mrg_sel = param_ff[6][1:0];
      end
      `FCS_CMD_PGMCHK: begin
        chk_acc = chk_acc | ~aligned | ~in_flash
                  | (param_ff[4] == 8'h00) | (param_ff[4] > 8'h02);
        mrg_sel = param_ff[4][1:0];
      end
      `FCS_CMD_RD1ALL: begin
        chk_acc = chk_acc | (param_ff[1] > 8'h02);
        mrg_sel = param_ff[1][1:0];
      end
      `FCS_CMD_RDRES:
        chk_acc = chk_acc | ~aligned | (param_ff[8] > 8'h01)
                  | (cmd_addr > ((param_ff[8] == 8'h00) ? 24'h0000FF
                                                        : 24'h000007));
      `FCS_CMD_PGM4, `FCS_CMD_ERSSECT: begin
        chk_acc  = chk_acc | ~aligned | ~in_flash;
        chk_prot = ~protect_ff[region]; // RULE8
      end
      `FCS_CMD_RDONCE, `FCS_CMD_PGMONCE:
        chk_acc = chk_acc | (param_ff[1] >= (`FCS_ONCE_BYTES / 4)); // RULE15
      `FCS_CMD_ERSALL:
        chk_prot = (protect_ff != 32'hFFFFFFFF); // RULE18
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus write strobes
  // ----------------------------------------------------------------
  wire wr_param   = wr & idle & pidx_h;
  wire wr_config  = wr & (paddr == `FCS_OFS_CONFIG);
  wire wr_protect = wr & idle & (paddr == `FCS_OFS_PROTECT);
  wire wr_mode    = wr & idle & (paddr == `FCS_OFS_MODE);
  wire wr_status  = wr & (paddr == `FCS_OFS_STATUS);
  wire launch     = wr_status & pwdata[`FCS_ST_CMD_COMPLETE_FLAG] & idle
                    & ~access_error_flag_ff & ~pviol_ff; // RULE5 RULE4
  wire chk_fail   = chk_acc | chk_prot;
  wire chk_pass   = (state_ff == ST_CHECK) & ~chk_fail;
  wire chk_stop   = (state_ff == ST_CHECK) & chk_fail;
  wire exec_done  = (state_ff == ST_EXEC) & (cnt_ff == 8'h00);
  wire keep_res   = (code == `FCS_CMD_RDRES) | (code == `FCS_CMD_RDONCE);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 8'h00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (launch) begin // RULE4
            state_ff <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (chk_fail) begin
            state_ff <= ST_IDLE; // RULE9
          end else begin
            cnt_ff   <= EXEC_CYC[7:0];
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (cnt_ff == 8'h00) begin
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command outputs
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cmd_start    <= 1'b0;
      cmd_code     <= 8'h00;
      margin_level <= `FCS_MRG_NORMAL;
    end else begin
      cmd_start <= 1'b0;
      if (chk_pass) begin
        cmd_start    <= 1'b1;
        cmd_code     <= code;
        margin_level <= mrg_sel; // RULE19
      end
      if (exec_done) begin
        margin_level <= `FCS_MRG_NORMAL; // RULE19
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cmd_complete_flag_ff   <= 1'b1; // RULE25
      access_error_flag_ff <= 1'b0;
      pviol_ff  <= 1'b0;
      rterr_ff  <= 1'b0;
      rdcol_ff  <= 1'b0;
    end else begin
      if (wr_status && pwdata[`FCS_ST_ACCESS_ERROR_FLAG]) begin
        access_error_flag_ff <= 1'b0;
      end
      if (wr_status && pwdata[`FCS_ST_PVIOL]) begin
        pviol_ff <= 1'b0;
      end
      if (wr_status && pwdata[`FCS_ST_RDCOL]) begin
        rdcol_ff <= 1'b0;
      end
      // Collision set wins over clear
      if (array_rd && !idle) begin
        rdcol_ff <= 1'b1; // RULE21
      end
      if (launch) begin
        cmd_complete_flag_ff  <= 1'b0; // RULE4
        rterr_ff <= 1'b0;
      end
      if (chk_stop) begin
        access_error_flag_ff <= chk_acc; // RULE7
        pviol_ff  <= chk_prot & ~chk_acc; // RULE8
        cmd_complete_flag_ff   <= 1'b1; // RULE9
      end
      if (exec_done) begin
        rterr_ff <= exec_fail; // RULE10
        cmd_complete_flag_ff  <= 1'b1; // RULE11
      end
    end
  end

  // ----------------------------------------------------------------
  // Parameter group
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      for (i = 0; i < `FCS_PARAM_NUM; i = i + 1) begin
        param_ff[i] <= 8'h00;
      end
    end else begin
      if (wr_param) begin
        param_ff[pidx] <= pwdata[7:0]; // RULE3 RULE2
      end
      if (exec_done && keep_res) begin
        param_ff[4] <= exec_rdata[31:24]; // RULE11
        param_ff[5] <= exec_rdata[23:16];
        param_ff[6] <= exec_rdata[15:8];
        param_ff[7] <= exec_rdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Config, protection and mode
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      complete_irq_enable_ff    <= 1'b0;
      rdcolie_ff <= 1'b0;
      protect_ff <= `FCS_RST_PROTECT;
      mode_ff    <= 4'h0;
    end else begin
      if (wr_config) begin
        complete_irq_enable_ff    <= pwdata[`FCS_CF_COMPLETE_IRQ_ENABLE];
        rdcolie_ff <= pwdata[`FCS_CF_RDCOLIE];
      end
      if (wr_protect) begin
        protect_ff <= pwdata; // RULE2
      end
      if (wr_mode) begin
        mode_ff <= pwdata[3:0]; // RULE2
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read decode
  // ----------------------------------------------------------------
  reg [31:0] nxt_prdata;
  reg        nxt_pslverr;
  always @* begin
    nxt_prdata  = 32'h00000000;
    nxt_pslverr = 1'b0;
    case (paddr)
      `FCS_OFS_STATUS: begin
        nxt_prdata = {24'h000000, cmd_complete_flag_ff, rdcol_ff, access_error_flag_ff, pviol_ff,
                      3'b000, rterr_ff};
      end
      `FCS_OFS_CONFIG: begin
        nxt_prdata = {24'h000000, complete_irq_enable_ff, rdcolie_ff, 6'h00};
      end
      `FCS_OFS_PROTECT: begin
        nxt_prdata = protect_ff;
      end
      `FCS_OFS_MODE: begin
        nxt_prdata = {28'h0000000, mode_ff};
      end
      `FCS_OFS_EXEC: begin
        nxt_prdata = {21'h00000, state_ff, code};
      end
      `FCS_OFS_MARGIN: begin
        nxt_prdata = {30'h0000000, margin_level};
      end
      default: begin
        if (pidx_h) begin
          nxt_prdata = {24'h000000, param_ff[pidx]};
        end else begin
          nxt_pslverr = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt request and APB answer
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_req <= 1'b0;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      irq_req <= (complete_irq_enable_ff & cmd_complete_flag_ff) | (rdcolie_ff & rdcol_ff); // RULE24
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        prdata  <= nxt_prdata;
        pslverr <= nxt_pslverr;
      end
    end
  end

endmodule // fcs_sequencer

// *** include/fcs_consts.vh ***
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FCS_OFS_STATUS   12'h000
`define FCS_OFS_CONFIG   12'h004
`define FCS_OFS_PROTECT  12'h008
`define FCS_OFS_MODE     12'h00C
`define FCS_OFS_EXEC     12'h010
`define FCS_OFS_MARGIN   12'h014
`define FCS_OFS_PARAM0   12'h020
`define FCS_PARAM_NUM    12
// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define FCS_ST_RTERR     0
`define FCS_ST_PVIOL     4
`define FCS_ST_ACCESS_ERROR_FLAG    5
`define FCS_ST_RDCOL     6
`define FCS_ST_CMD_COMPLETE_FLAG      7
// ----------------------------------------------------------------
// Config bit positions
// ----------------------------------------------------------------
`define FCS_CF_RDCOLIE   6
`define FCS_CF_COMPLETE_IRQ_ENABLE      7
// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define FCS_MD_SPECIAL   0
`define FCS_MD_SECURE    1
`define FCS_MD_MASS_ERASE_ENABLE_FIELD_LO   2
`define FCS_MASS_ERASE_ENABLE_FIELD_DIS     2'h2
// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FCS_CMD_RD1SECT  8'h01
`define FCS_CMD_PGMCHK   8'h02
`define FCS_CMD_RDRES    8'h03
`define FCS_CMD_PGM4     8'h06
`define FCS_CMD_ERSSECT  8'h09
`define FCS_CMD_RD1ALL   8'h40
`define FCS_CMD_RDONCE   8'h41
`define FCS_CMD_PGMONCE  8'h43
`define FCS_CMD_ERSALL   8'h44
`define FCS_CMD_VFYKEY   8'h45
// ----------------------------------------------------------------
// Margin levels, limits and reset values
// ----------------------------------------------------------------
`define FCS_MRG_NORMAL   2'h0
`define FCS_MRG_USER     2'h1
`define FCS_MRG_FACTORY  2'h2
`define FCS_ONCE_BYTES   64
`define FCS_EXEC_CYC     8
`define FCS_FLASH_SIZE   24'h010000
`define FCS_RST_STATUS   8'h80
`define FCS_RST_PROTECT  32'hFFFFFFFF
`endif

// *** verification/fcs_sequencer_assertions.sv ***
`timescale 1ns/100ps
module fcs_chk (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        array_rd,
  input wire        exec_fail,
  input wire [31:0] exec_rdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        cmd_start,
  input wire [7:0]  cmd_code,
  input wire [1:0]  margin_level,
  input wire        irq_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------
  // Bus and command checks
  // ------------------------------------------------
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  phase_ready_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  no_wait_a: assert property (psel && !penable |=> pready)
    else $error("access phase not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  start_gap_a: assert property (
    cmd_start |=> !cmd_start [*8]) else $error("start while busy");
  start_code_a: assert property (
    cmd_start |=> cmd_code inside {8'h01, 8'h02, 8'h03, 8'h06, 8'h09,
    8'h40, 8'h41, 8'h43, 8'h44, 8'h45}) else $error("bad code started");
  margin_cmd_a: assert property (
    margin_level != 2'h0 |-> cmd_code inside {8'h01, 8'h02, 8'h40})
    else $error("margin outside margin command");
  reset_idle_a: assert property (
    $fell(sys_rst) |-> !cmd_start && !irq_req && margin_level == 2'h0)
    else $error("outputs busy after reset");
  cover property (cmd_start);
  cover property (pslverr);
  cover property (psel && penable && pwrite && pready);
endmodule // fcs_chk

// *** verification/test_fcs_sequencer.sv ***
`timescale 1ns/100ps
`include "fcs_consts.vh"
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin \
  fail_count++; $display("BAD %0t %h %h", $time, g, x); end end
module test_fcs_sequencer;
  logic        ref_clk = 0, sys_rst = 1, psel = 0, penable = 0;
  logic        pwrite = 0, array_rd = 0, exec_fail = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, exec_rdata = 0, q;
  wire  [31:0] prdata;
  wire         pready, pslverr, cmd_start, irq_req;
  wire  [7:0]  cmd_code;
  wire  [1:0]  margin_level;
  int          fail_count = 0, tests_run = 0, cyc = 0, starts = 0;
  logic [7:0]  last_code = 0;
  logic [1:0]  last_mrg = 0;
  localparam logic [11:0] ST = `FCS_OFS_STATUS, P0 = `FCS_OFS_PARAM0;
  localparam logic [11:0] P1 = P0 + 12'h004, P2 = P0 + 12'h008;
  localparam logic [11:0] P3 = P0 + 12'h00C, MD = `FCS_OFS_MODE;
  fcs_sequencer DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .array_rd(array_rd), .exec_fail(exec_fail), .exec_rdata(exec_rdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_start(cmd_start), .cmd_code(cmd_code),
    .margin_level(margin_level), .irq_req(irq_req));
  always #2 ref_clk = ~ref_clk;
  // ------------------------------------------------
  // Bus tasks
  // ------------------------------------------------
  task automatic end_sim;
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cmd_start === 1'b1) begin
      starts <= starts + 1;
      last_code <= cmd_code;
      last_mrg <= margin_level;
    end
    if (cyc == 6000) begin
      fail_count++;
      end_sim;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wrt(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask
  task automatic go(input logic [7:0] c, hi, m, x, input int n);
    wrt(P3, 32'h0);
    wrt(P2, 32'h1);
    wrt(P1, {24'h0, hi});
    wrt(P0, {24'h0, c});
    run(m, x, n);
  endtask
  task automatic run(input logic [7:0] m, x, input int n);
    int s0;
    s0 = starts;
    wrt(ST, 32'h80);
    q = 32'h0;
    for (int i = 0; i < 40 && q[7] !== 1'b1; i++)
      apb(1'b0, ST, 32'h0);
    `CHK(q[7:0] & m, x)
    `CHK(starts - s0, n)
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_regs;
    rdc(ST, 32'h80);
    rdc(`FCS_OFS_PROTECT, 32'hFFFFFFFF);
    wrt(P2, 32'h34);
    wrt(P0, 32'h12);
    rdc(P2, 32'h34);
    rdc(P0, 32'h12);
    apb(1'b0, 12'hFFC, 32'h0);
    `CHK(e, 1'b1)
  endtask
  task automatic t_busy;
    go(8'h06, 8'h00, 8'hFF, 8'h80, 1);
    go(8'h09, 8'h00, 8'hFF, 8'h80, 1);
    wrt(ST, 32'h80);
    array_rd <= 1'b1;
    wrt(P0, 32'hAA);
    array_rd <= 1'b0;
    rdc(P0, 32'h09);
    rdc(ST, 32'h40);
    repeat (12) apb(1'b0, ST, 32'h0);
    `CHK(q, 32'hC0)
    wrt(ST, 32'h40);
    rdc(ST, 32'h80);
    exec_fail <= 1'b1;
    go(8'h06, 8'h00, 8'hFF, 8'h81, 1);
    exec_fail <= 1'b0;
    go(8'h06, 8'h00, 8'hFF, 8'h80, 1);
  endtask
  task automatic t_cmds;
    exec_rdata <= 32'h11223344;
    wrt(P3, 32'h0);
    wrt(P2, 32'h0);
    wrt(P0, 32'h03);
    run(8'hFF, 8'h80, 1);
    `CHK(last_code, 8'h03)
    rdc(P0 + 12'h010, 32'h11);
    rdc(P0 + 12'h01C, 32'h44);
    wrt(P0 + 12'h018, 32'h1);
    wrt(P0, 32'h01);
    run(8'hFF, 8'h80, 1);
    `CHK(last_mrg, 2'h1)
    `CHK(margin_level, 2'h0)
    wrt(P0 + 12'h010, 32'h0);
    wrt(P0, 32'h02);
    run(8'hFF, 8'hA0, 0);
    wrt(ST, 32'h20);
    wrt(P1, 32'h2);
    wrt(P0, 32'h40);
    run(8'hFF, 8'h80, 1);
    `CHK(last_mrg, 2'h2)
    exec_rdata <= 32'h55667788;
    wrt(P0, 32'h41);
    run(8'hFF, 8'h80, 1);
    rdc(P0 + 12'h010, 32'h55);
    wrt(P1, 32'h10);
    wrt(P0, 32'h43);
    run(8'hFF, 8'hA0, 0);
    wrt(ST, 32'h20);
    wrt(P0, 32'h45);
    run(8'hFF, 8'h80, 1);
    `CHK(last_code, 8'h45)
    wrt(`FCS_OFS_CONFIG, 32'h80);
    rdc(`FCS_OFS_CONFIG, 32'h80);
    `CHK(irq_req, 1'b1)
    wrt(`FCS_OFS_CONFIG, 32'h0);
    rdc(`FCS_OFS_CONFIG, 32'h0);
    `CHK(irq_req, 1'b0)
    wrt(P1, 32'h0);
  endtask
  task automatic t_err;
    go(8'hFF, 8'h00, 8'hFF, 8'hA0, 0);
    go(8'h06, 8'h00, 8'hFF, 8'hA0, 0);
    wrt(ST, 32'h20);
    rdc(ST, 32'h80);
    go(8'h06, 8'h00, 8'hFF, 8'h80, 1);
    go(8'h06, 8'h02, 8'hFF, 8'hA0, 0);
    wrt(ST, 32'h20);
    wrt(MD, 32'h3);
    go(8'h06, 8'h00, 8'hFF, 8'hA0, 0);
    wrt(ST, 32'h20);
    go(8'h44, 8'h00, 8'hFF, 8'h80, 1);
    wrt(MD, 32'hB);
    go(8'h44, 8'h00, 8'hFF, 8'hA0, 0);
    wrt(ST, 32'h20);
    wrt(MD, 32'h0);
    wrt(`FCS_OFS_PROTECT, 32'h0);
    go(8'h06, 8'h00, 8'hFF, 8'h90, 0);
    wrt(ST, 32'h10);
    go(8'h44, 8'h00, 8'h80, 8'h80, 0);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_busy;
    t_cmds;
    t_err;
    end_sim;
  end
endmodule // test_fcs_sequencer
bind fcs_sequencer fcs_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .array_rd(array_rd), .exec_fail(exec_fail),
  .exec_rdata(exec_rdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmd_start(cmd_start), .cmd_code(cmd_code),
  .margin_level(margin_level), .irq_req(irq_req));
